// ===== src/imu_status_defs.svh
// register offsets, field positions and reset values of the status and time-stamp bank
`ifndef IMU_STATUS_DEFS_SVH
`define IMU_STATUS_DEFS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define ADDR_OUTPUT_DATA_STATUS 8'h16
`define ADDR_MISC_STATUS 8'h17
`define ADDR_SAMPLE_STAMP_COUNT 8'h18
`define ADDR_ACCEL_X_LOW_BYTE 8'h19
`define ADDR_ACCEL_X_HIGH_BYTE 8'h1A
`define ADDR_LAST_OUTPUT_BYTE 8'h1A

// ----------------------------------------------------------------------------
// output_data_status fields
// ----------------------------------------------------------------------------
`define BIT_FUSION_OVERRUN 7
`define BIT_MAG_OVERRUN 6
`define BIT_GYRO_OVERRUN 5
`define BIT_ACCEL_OVERRUN 4
`define BIT_FUSION_NEW 3
`define BIT_MAG_VALID 2
`define BIT_GYRO_NEW 1
`define BIT_ACCEL_NEW 0

// ----------------------------------------------------------------------------
// misc_status fields
// ----------------------------------------------------------------------------
`define BIT_MOTION_WAKE 2
`define BIT_FIFO_READY 1
`define BIT_CMD_DONE 0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_STATUS_BYTE 8'h00
`define RST_STAMP_COUNT 8'h00
`define RST_ACCEL_WORD 16'h0000
`define RST_READ_DATA 8'h00

`endif

// ===== src/imu_status_pkg.sv
// types shared by the status and time-stamp register bank
package imu_status_pkg;

  // --------------------------------------------------------------------------
  // output register update mode
  // --------------------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_UPDATING = 1'b0,
    ST_FROZEN = 1'b1
  } update_state_e;

  // --------------------------------------------------------------------------
  // per-source sticky flags
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic fusion_overrun;
    logic mag_overrun;
    logic gyro_overrun;
    logic accel_overrun;
    logic fusion_new;
    logic mag_valid;
    logic gyro_new;
    logic accel_new;
  } status_flags_s;

  // --------------------------------------------------------------------------
  // whole state of the bank
  // --------------------------------------------------------------------------
  typedef struct packed {
    update_state_e state;
    status_flags_s flags;
    logic motion_wake;
    logic [7:0] stamp;
    logic [15:0] accel_x_pending;
    logic [15:0] accel_x_out;
    logic [15:0] mag_pending;
    logic mag_pending_valid;
    logic [15:0] mag_out;
    logic data_ready;
    logic [7:0] rd_data;
  } bank_state_s;

endpackage : imu_status_pkg

// ===== src/imu_status_timestamp_regs.sv
// status, sample time-stamp and accel X output registers of the motion sensor
`timescale 1ns/100ps
`include "imu_status_defs.svh"

module imu_status_timestamp_regs
  import imu_status_pkg::*;
(
  input wire logic i_clk_sys, // 40 MHz device clock
  input wire logic i_sys_rst, // power-on reset, async, high
  input wire logic i_rd_en, // host register read strobe, one cycle
  input wire logic [7:0] i_rd_addr, // host register address
  output logic [7:0] o_rd_data, // read data, valid cycle after strobe
  input wire logic i_level_sync_sampling_select, // 1 = level mode, 0 = edge mode
  input wire logic i_odr_tick, // output data rate tick, pulse
  input wire logic i_fast_sample, // fastest sensor x/y/z set done, pulse
  input wire logic i_accel_new, // accelerometer sample, pulse
  input wire logic [15:0] i_accel_x, // accel X sample, two's complement
  input wire logic i_gyro_new, // gyroscope sample, pulse
  input wire logic i_mag_new, // magnetometer sample, pulse
  input wire logic [15:0] i_mag_sample, // magnetometer sample word
  input wire logic i_mag_enable, // magnetometer running, level
  input wire logic i_fusion_new, // fusion engine result, pulse
  input wire logic i_motion_wake, // wake-on-motion detected, pulse
  input wire logic i_fifo_ready, // FIFO has data for host, level
  input wire logic i_cmd_done, // host command completed, level
  output logic o_data_ready, // data-ready interrupt line
  output logic [15:0] o_mag_out // magnetometer word at output rate
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------

  // new-data flag: set wins over the read clear so no sample is lost
  function automatic logic next_new(input logic cur, input logic evt, input logic clr);
    next_new = evt | (cur & ~clr);
  endfunction : next_new

  // overrun: a new sample lands while the previous one is still unread
  function automatic logic next_ovr(input logic cur, input logic pend, input logic evt,
                                    input logic clr);
    next_ovr = (evt & pend & ~clr) | (cur & ~clr);
  endfunction : next_ovr

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  bank_state_s s_q;
  bank_state_s s_d;
  logic status_read;
  logic last_read;
  logic publish;
  logic [7:0] status_byte;
  logic [7:0] misc_byte;

  // host read decode
  assign status_read = i_rd_en & (i_rd_addr == `ADDR_OUTPUT_DATA_STATUS);
  assign last_read = i_rd_en & (i_rd_addr == `ADDR_LAST_OUTPUT_BYTE);

  // outputs only refresh at a tick while not frozen by a level-mode read
  assign publish = i_odr_tick & (s_q.state == ST_UPDATING);

  // status byte assembly from the flags
  always_comb begin
    status_byte = `RST_STATUS_BYTE;
    status_byte[`BIT_FUSION_OVERRUN] = s_q.flags.fusion_overrun;
    status_byte[`BIT_MAG_OVERRUN] = s_q.flags.mag_overrun;
    status_byte[`BIT_GYRO_OVERRUN] = s_q.flags.gyro_overrun;
    status_byte[`BIT_ACCEL_OVERRUN] = s_q.flags.accel_overrun;
    status_byte[`BIT_FUSION_NEW] = s_q.flags.fusion_new;
    status_byte[`BIT_MAG_VALID] = s_q.flags.mag_valid;
    status_byte[`BIT_GYRO_NEW] = s_q.flags.gyro_new;
    status_byte[`BIT_ACCEL_NEW] = s_q.flags.accel_new;
  end

  // misc status byte; reserved bits 7:3 read zero
  always_comb begin
    misc_byte = `RST_STATUS_BYTE;
    misc_byte[`BIT_MOTION_WAKE] = s_q.motion_wake;
    misc_byte[`BIT_FIFO_READY] = i_fifo_ready;
    misc_byte[`BIT_CMD_DONE] = i_cmd_done;
  end

  // --------------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // sticky new-data and overrun flags, cleared by a status read
    s_d.flags.accel_new = next_new(s_q.flags.accel_new, i_accel_new, status_read);
    s_d.flags.gyro_new = next_new(s_q.flags.gyro_new, i_gyro_new, status_read);
    s_d.flags.fusion_new = next_new(s_q.flags.fusion_new, i_fusion_new, status_read);
    s_d.flags.accel_overrun = next_ovr(s_q.flags.accel_overrun, s_q.flags.accel_new,
                                       i_accel_new, status_read);
    s_d.flags.gyro_overrun = next_ovr(s_q.flags.gyro_overrun, s_q.flags.gyro_new,
                                      i_gyro_new, status_read);
    s_d.flags.fusion_overrun = next_ovr(s_q.flags.fusion_overrun, s_q.flags.fusion_new,
                                        i_fusion_new, status_read);
    // mag overrun: a pending sample not yet published gets replaced
    s_d.flags.mag_overrun = next_ovr(s_q.flags.mag_overrun, s_q.mag_pending_valid & ~publish,
                                     i_mag_new, status_read);

    // mag valid is a level, not cleared by a read: data repeats every tick
    if (!i_mag_enable) begin
      s_d.flags.mag_valid = 1'b0;
    end else if (publish && (s_q.mag_pending_valid || s_q.flags.mag_valid)) begin
      s_d.flags.mag_valid = 1'b1;
    end

    // wake-on-motion latches; the wider device owns its clearing
    s_d.motion_wake = s_q.motion_wake | i_motion_wake;

    // time stamp counter, 8-bit natural wrap 0xFF -> 0x00
    if (i_fast_sample) begin
      s_d.stamp = s_q.stamp + 8'h01;
    end

    // capture the latest accel and mag samples between ticks
    if (i_accel_new) begin
      s_d.accel_x_pending = i_accel_x;
    end
    if (i_mag_new) begin
      s_d.mag_pending = i_mag_sample;
      s_d.mag_pending_valid = 1'b1;
    end

    // publish at the tick; a slow mag simply leaves mag_out repeating
    if (publish) begin
      s_d.accel_x_out = s_q.accel_x_pending;
      if (s_q.mag_pending_valid) begin
        s_d.mag_out = s_q.mag_pending;
      end
      s_d.mag_pending_valid = i_mag_new;
    end

    // data-ready: pulse per tick in edge mode, level until read in level mode
    if (!i_level_sync_sampling_select) begin
      s_d.data_ready = i_odr_tick;
    end else if (status_read) begin
      s_d.data_ready = 1'b0;
    end else if (publish) begin
      s_d.data_ready = 1'b1;
    end

    // freeze control
    unique case (s_q.state)
      ST_UPDATING: begin
        if (i_level_sync_sampling_select && status_read) begin
          s_d.state = ST_FROZEN;
        end
      end
      ST_FROZEN: begin
        // leaving level mode also releases, else outputs would stall forever
        if (last_read || !i_level_sync_sampling_select) begin
          s_d.state = ST_UPDATING;
        end
      end
    endcase

    // registered read data
    if (i_rd_en) begin
      unique case (i_rd_addr)
        `ADDR_OUTPUT_DATA_STATUS: s_d.rd_data = status_byte;
        `ADDR_MISC_STATUS: s_d.rd_data = misc_byte;
        `ADDR_SAMPLE_STAMP_COUNT: s_d.rd_data = s_q.stamp;
        `ADDR_ACCEL_X_LOW_BYTE: s_d.rd_data = s_q.accel_x_out[7:0];
        `ADDR_ACCEL_X_HIGH_BYTE: s_d.rd_data = s_q.accel_x_out[15:8];
        default: s_d.rd_data = `RST_READ_DATA;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
      s_q.state <= ST_UPDATING;
      s_q.stamp <= `RST_STAMP_COUNT;
      s_q.accel_x_out <= `RST_ACCEL_WORD;
      s_q.rd_data <= `RST_READ_DATA;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign o_rd_data = s_q.rd_data;
  assign o_data_ready = s_q.data_ready;
  assign o_mag_out = s_q.mag_out;

endmodule : imu_status_timestamp_regs

// ===== bench/imu_status_sva.sv
// assertion checker for the status and time-stamp register bank
`timescale 1ns/100ps
module imu_status_sva (
  input wire logic i_clk_sys, // clock
  input wire logic i_sys_rst, // reset
  input wire logic i_rd_en, // read strobe
  input wire logic [7:0] i_rd_addr, // address
  input wire logic [7:0] o_rd_data, // read data
  input wire logic i_level_sync_sampling_select, // mode
  input wire logic i_odr_tick, // rate tick
  input wire logic i_accel_new, // accel event
  input wire logic i_gyro_new, // gyro event
  input wire logic i_mag_new, // mag event
  input wire logic i_fusion_new, // fusion event
  input wire logic i_motion_wake, // wake event
  input wire logic i_fifo_ready, // fifo level
  input wire logic i_cmd_done, // done level
  input wire logic o_data_ready, // interrupt
  input wire logic [15:0] o_mag_out // mag word
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  wire rd_st = i_rd_en && (i_rd_addr == 8'h16); // status read
  wire rd_misc = i_rd_en && (i_rd_addr == 8'h17); // misc read
  wire lvl = i_level_sync_sampling_select; // short alias
  wire quiet = !(i_accel_new || i_gyro_new || i_mag_new || i_fusion_new); // no accel, gyro, mag or fusion event
  // accel sample followed by a cycle without a status read
  sequence acc_gap;
    i_accel_new ##1 !rd_st;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_unmapped_zero: assert property (
    i_rd_en && !(i_rd_addr inside {[8'h16:8'h1A]}) |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_misc_live: assert property (
    rd_misc |=> o_rd_data[7:3] == 5'h00 && o_rd_data[1:0] == {$past(i_fifo_ready), $past(i_cmd_done)})
    else $error("misc status byte wrong");
  a_wake_seen: assert property (
    i_motion_wake ##2 rd_misc |=> o_rd_data[2]) else $error("wake flag missing");
  a_edge_ready: assert property (
    !lvl && !$past(lvl) |-> o_data_ready == $past(i_odr_tick))
    else $error("edge mode ready not tick delayed");
  a_level_drop: assert property (
    lvl && rd_st |=> !o_data_ready) else $error("ready not dropped by status read");
  a_status_clears: assert property (
    (rd_st && quiet) ##1 quiet ##1 (rd_st && quiet) |=> (o_rd_data & 8'hFB) == 8'h00)
    else $error("status flags not cleared by read");
  a_accel_new: assert property (
    acc_gap ##1 !rd_st ##1 rd_st |=> o_rd_data[0]) else $error("accel new flag missing");
  a_accel_ovr: assert property (
    acc_gap ##1 acc_gap ##1 !rd_st ##1 rd_st |=> o_rd_data[4])
    else $error("accel overrun missing");
  a_mag_hold: assert property (
    $changed(o_mag_out) |-> $past(i_odr_tick)) else $error("mag word changed off tick");
endmodule : imu_status_sva

bind imu_status_timestamp_regs imu_status_sva u_sva (.*);

// ===== bench/host_model.sv
// host processor model reading the bank one byte at a time
`timescale 1ns/100ps
module host_model (
  input wire logic i_clk_sys, // device clock
  input wire logic [7:0] i_rd_data, // byte from the bank
  output logic o_rd_en, // read strobe
  output logic [7:0] o_rd_addr // register address
);
  // idle bus before any access
  initial begin
    o_rd_en = 1'b0;
    o_rd_addr = 8'hFF;
  end
  // strobe held over one edge; the byte is settled just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    #2;
    o_rd_en = 1'b1;
    o_rd_addr = a;
    @(posedge i_clk_sys);
    #2;
    o_rd_en = 1'b0;
    o_rd_addr = ~a; // released address moves so stale values cannot pass
    d = i_rd_data;
  endtask : rd
endmodule : host_model

// ===== bench/imu_status_timestamp_regs_test.sv
// self-checking bench for the status and time-stamp register bank
`timescale 1ns/100ps
module imu_status_timestamp_regs_test;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic lvl = 1'b0;
  logic mag_en = 1'b1; // magnetometer running
  logic [6:0] evt = 7'h00; // wake, tick, fusion, mag, gyro, accel, fast
  logic i_fifo_ready = 1'b0;
  logic i_cmd_done = 1'b0;
  logic [15:0] i_accel_x = 16'h0000;
  logic [15:0] i_mag_sample = 16'h0000;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic o_data_ready;
  logic [15:0] o_mag_out;
  logic [7:0] d;
  int mismatches = 0;
  int cmp_count = 0;
  // ----------------------------------------------------------------
  // clock, device and host
  // ----------------------------------------------------------------
  always #12.5 i_clk_sys = ~i_clk_sys;
  imu_status_timestamp_regs DUT (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
    .i_level_sync_sampling_select(lvl), .i_odr_tick(evt[5]), .i_fast_sample(evt[0]),
    .i_accel_new(evt[1]), .i_accel_x(i_accel_x), .i_gyro_new(evt[2]),
    .i_mag_new(evt[3]), .i_mag_sample(i_mag_sample), .i_mag_enable(mag_en),
    .i_fusion_new(evt[4]), .i_motion_wake(evt[6]), .i_fifo_ready(i_fifo_ready),
    .i_cmd_done(i_cmd_done), .o_data_ready(o_data_ready), .o_mag_out(o_mag_out));
  host_model host (.i_clk_sys(i_clk_sys), .i_rd_data(rd_data), .o_rd_en(rd_en),
    .o_rd_addr(rd_addr));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d);
    chk_byte(d, exp);
  endtask : rd_chk
  // one-cycle event pulses; a gap cycle keeps pulses apart
  task automatic ev(input logic [6:0] m);
    @(posedge i_clk_sys);
    #2;
    evt = m;
    @(posedge i_clk_sys);
    #2;
    evt = 7'h00;
  endtask : ev
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // watchdog: the run needs well under 2000 cycles
  // ----------------------------------------------------------------
  initial begin
    #125000;
    mismatches++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge i_clk_sys);
    #2;
    i_sys_rst = 1'b0;
    for (int a = 8'h15; a <= 8'h1B; a++) rd_chk(8'(a), 8'h00);
    ev(7'h1E);
    rd_chk(8'h16, 8'h0B);
    rd_chk(8'h16, 8'h00);
    ev(7'h1E);
    ev(7'h1E);
    rd_chk(8'h16, 8'hFB);
    i_accel_x = 16'h8123;
    i_mag_sample = 16'h0A5C;
    ev(7'h0A);
    ev(7'h20);
    chk_byte({7'h00, o_data_ready}, 8'h01);
    rd_chk(8'h16, 8'h45);
    rd_chk(8'h19, 8'h23);
    rd_chk(8'h1A, 8'h81);
    chk_word(o_mag_out, 16'h0A5C);
    ev(7'h20);
    chk_word(o_mag_out, 16'h0A5C);
    rd_chk(8'h16, 8'h04);
    lvl = 1'b1;
    i_accel_x = 16'h1234;
    ev(7'h02);
    ev(7'h20);
    chk_byte({7'h00, o_data_ready}, 8'h01);
    rd_chk(8'h16, 8'h05);
    chk_byte({7'h00, o_data_ready}, 8'h00);
    i_accel_x = 16'h5678;
    ev(7'h02);
    ev(7'h20);
    rd_chk(8'h19, 8'h34);
    rd_chk(8'h1A, 8'h12);
    ev(7'h20);
    rd_chk(8'h19, 8'h78);
    i_fifo_ready = 1'b1;
    i_cmd_done = 1'b1;
    ev(7'h40);
    rd_chk(8'h17, 8'h07);
    i_fifo_ready = 1'b0;
    i_cmd_done = 1'b0;
    rd_chk(8'h17, 8'h04);
    repeat (257) ev(7'h01);
    rd_chk(8'h18, 8'h01);
    mag_en = 1'b0;
    rd_chk(8'h16, 8'h01);
    wrap_up();
  end
endmodule : imu_status_timestamp_regs_test
